/* File: core/jkd_flop.sv */
// Module: steered toggle storage element with optional direct set and clear
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: State samples steering and updates only at the falling element-clock transition.
// RULE2: Prior state for the next-state function is the true output before that edge.
// RULE3: Driver keeps both direct inputs low whenever clocked operation is intended.
// RULE4: Driver holds the element clock steady while direct inputs force the state.
// RULE5: After one direct input releases, the forced state is kept.
// RULE6: Both direct inputs falling together leaves an unpredictable state.
// RULE7: Direct inputs exist only when HAS_DIRECT is set; clocked behaviour always same.
// RULE8: Direct set gives 1/0, clear gives 0/1, both give 0/0, without the clock.
// RULE9: Edge: both high hold, a only set, b only clear, both low toggle.
// RULE10: Complement is inverse of true output, except both low under double force.
module jkd_flop #(
  parameter bit HAS_DIRECT = 1'b1
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Element clock and steering
  input wire logic elem_clk,
  input wire jkd_pkg::jkd_steer_s steer,
  // Direct force inputs
  input wire jkd_pkg::jkd_direct_s direct,
  // Outputs
  output logic q_true,
  output logic q_comp
);

  // ****************************************
  // Edge detect and direct-mode decode
  // ****************************************
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic state_r;
  logic state_nxt;
  logic q_true_nxt;
  logic q_comp_nxt;
  jkd_pkg::jkd_dir_e dir_mode;
  jkd_pkg::jkd_dir_e dir_prev_r;
  jkd_pkg::jkd_dir_e dir_prev_nxt;
  logic fall_edge;

  function automatic jkd_pkg::jkd_dir_e decode_dir(input jkd_pkg::jkd_direct_s d);
    if (!HAS_DIRECT) begin // RULE7
      return jkd_pkg::JKD_DIR_IDLE;
    end
    case ({d.force_set, d.force_clr})
      2'h2: return jkd_pkg::JKD_DIR_SET;
      2'h1: return jkd_pkg::JKD_DIR_CLR;
      2'h3: return jkd_pkg::JKD_DIR_BOTH;
      default: return jkd_pkg::JKD_DIR_IDLE;
    endcase
  endfunction

  // Element clock is a plain input sampled on clk_sys; a fall is seen at the first clk_sys edge that samples it low
  assign fall_edge = clk_prev_r & ~elem_clk; // RULE1
  assign dir_mode = decode_dir(direct);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    clk_prev_nxt = elem_clk;
    dir_prev_nxt = dir_mode;
    state_nxt = state_r;
    case (dir_mode)
      jkd_pkg::JKD_DIR_SET: begin
        state_nxt = 1'h1; // RULE8
      end
      jkd_pkg::JKD_DIR_CLR: begin
        state_nxt = 1'h0; // RULE8
      end
      jkd_pkg::JKD_DIR_BOTH: begin
        state_nxt = 1'h0; // RULE8
      end
      jkd_pkg::JKD_DIR_IDLE: begin
        // Double release: unpredictable in silicon; we resolve to the held 0
        if (dir_prev_r == jkd_pkg::JKD_DIR_BOTH) begin
          state_nxt = state_r; // RULE6
        end else if (fall_edge) begin // RULE1
          case ({steer.steer_a, steer.steer_b}) // RULE9
            2'h3: state_nxt = state_r;
            2'h2: state_nxt = 1'h1;
            2'h1: state_nxt = 1'h0;
            default: state_nxt = ~q_true; // RULE2
          endcase
        end else begin
          state_nxt = state_r; // RULE5
        end
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
    q_true_nxt = state_nxt;
    q_comp_nxt = (dir_mode == jkd_pkg::JKD_DIR_BOTH) ? 1'h0 : ~state_nxt; // RULE10
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_prev_r <= jkd_pkg::JKD_CLK_RST;
      dir_prev_r <= jkd_pkg::JKD_DIR_IDLE;
      state_r <= jkd_pkg::JKD_STATE_RST;
      q_true <= jkd_pkg::JKD_STATE_RST;
      q_comp <= ~jkd_pkg::JKD_STATE_RST;
    end else begin
      clk_prev_r <= clk_prev_nxt;
      dir_prev_r <= dir_prev_nxt;
      state_r <= state_nxt;
      q_true <= q_true_nxt;
      q_comp <= q_comp_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: core/jkd_pkg.sv */
// Package: shared types and constants for the steered toggle element
package jkd_pkg;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic JKD_STATE_RST = 1'h0;
  localparam logic JKD_CLK_RST = 1'h0;

  // ****************************************
  // Direct-input mode encoding (one-hot)
  // ****************************************
  typedef enum logic [3:0] {
    JKD_DIR_IDLE = 4'h1,
    JKD_DIR_SET = 4'h2,
    JKD_DIR_CLR = 4'h4,
    JKD_DIR_BOTH = 4'h8
  } jkd_dir_e;

  // Steering pair sampled at the falling clock edge
  typedef struct packed {
    logic steer_a;
    logic steer_b;
  } jkd_steer_s;

  // Direct force pair
  typedef struct packed {
    logic force_set;
    logic force_clr;
  } jkd_direct_s;

endpackage

/* File: dv/jkd_gates.sv */
// Gate logic model that makes the element clock
`timescale 1ns/1ps
`default_nettype none
module jkd_gates (
  input wire logic clk_sys,
  input wire logic go,
  output logic elem_clk = 1'h0
);
  always @(negedge clk_sys) elem_clk <= go;
endmodule
`default_nettype wire

/* File: dv/jkd_flop_properties.sv */
// Port checker for the steered element
`timescale 1ns/1ps
`default_nettype none
module jkd_flop_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic elem_clk,
  input wire jkd_pkg::jkd_steer_s steer,
  input wire jkd_pkg::jkd_direct_s direct,
  input wire logic q_true,
  input wire logic q_comp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_stb; (direct == 2'h0 && $stable(elem_clk)) [*3] |=> $stable(q_true); endproperty
  a_stb: assert property (p_stb) else $error("q moved without a fall");
  property p_sc; $fell(elem_clk) && direct == 2'h0 && steer[1] != steer[0]
    |-> ##2 q_true == $past(steer[1], 2); endproperty
  a_sc: assert property (p_sc) else $error("set or clear wrong");
  property p_tg; $fell(elem_clk) && direct == 2'h0 && steer[1] == steer[0]
    |-> ##2 q_true == ($past(q_true, 2) ^ !$past(steer[1], 2)); endproperty
  a_tg: assert property (p_tg) else $error("hold or toggle wrong");
  property p_set; direct == 2'h2 |=> q_true && !q_comp; endproperty
  a_set: assert property (p_set) else $error("direct set wrong");
  property p_clr; direct == 2'h1 |=> !q_true && q_comp; endproperty
  a_clr: assert property (p_clr) else $error("direct clear wrong");
  property p_both; direct == 2'h3 |=> !q_true && !q_comp; endproperty
  a_both: assert property (p_both) else $error("double force wrong");
  property p_keep; $past(direct) inside {2'h1, 2'h2} && direct == 2'h0
    |=> q_true == $past(q_true); endproperty
  a_keep: assert property (p_keep) else $error("release lost state");
  property p_cmp; direct != 2'h3 && $past(direct) != 2'h3 |-> q_comp == !q_true; endproperty
  a_cmp: assert property (p_cmp) else $error("outputs not complementary");
endmodule
bind jkd_flop jkd_flop_properties u_props (.clk_sys, .sys_rst, .elem_clk, .steer, .direct,
  .q_true, .q_comp);
`default_nettype wire

/* File: dv/jkd_flop_test.sv */
// Bench for the steered element
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module jkd_flop_test;
  logic clk_sys = 1'h0, sys_rst = 1'h1, go = 1'h0, elem_clk, q_true, q_comp;
  jkd_pkg::jkd_steer_s steer = 2'h0;
  jkd_pkg::jkd_direct_s direct = 2'h0;
  int failures = 0, num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  jkd_gates u_gates (.*);
  jkd_flop dut (.*);
  task wrap_up;
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One clock pulse; steering held until the next one
  task op(input logic [1:0] s, input logic e);
    @(negedge clk_sys);
    steer <= s;
    go <= 1'h1;
    @(negedge clk_sys);
    go <= 1'h0;
    repeat (5) @(negedge clk_sys);
    `CHK({q_true, q_comp}, {e, !e})
  endtask
  // Element clock stays low while forcing
  task force_to(input logic [1:0] d, input logic [1:0] e);
    @(negedge clk_sys);
    direct <= d;
    repeat (2) @(negedge clk_sys);
    `CHK({q_true, q_comp}, e)
  endtask
  task t_clocked;
    op(2'h0, 1'h1);
    op(2'h3, 1'h1);
    op(2'h1, 1'h0);
    op(2'h2, 1'h1);
    op(2'h0, 1'h0);
  endtask
  task t_direct;
    force_to(2'h2, 2'h2);
    force_to(2'h0, 2'h2);
    force_to(2'h1, 2'h1);
    force_to(2'h0, 2'h1);
    force_to(2'h3, 2'h0);
    direct <= 2'h0;
    op(2'h2, 1'h1);
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst <= 1'h0;
    `CHK({q_true, q_comp}, 2'h1)
    t_clocked;
    t_direct;
    wrap_up;
  end
  initial begin
    #20000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
